//--- common/lsl_regs.svh
`ifndef LSL_REGS_SVH
`define LSL_REGS_SVH

// Channel count and status word layout.
`define LSL_CHANNELS        16
`define LSL_ALL_ONES        16'hFFFF

// Register byte offsets on the AXI4-Lite slave.
`define LSL_OFS_CTRL        4'h0
`define LSL_OFS_ONOFF       4'h4
`define LSL_OFS_SHIFT       4'h8
`define LSL_OFS_STATUS      4'hC
`define LSL_ADDR_W          4

// Field positions.
`define LSL_CTRL_SOFT_BLANK 0
`define LSL_STAT_OVERTEMP   16
`define LSL_STAT_ON_OK      17
`define LSL_STAT_HOT_NOW    18

// Reset values.
`define LSL_CTRL_RST        1'b0

// AXI response codes.
`define LSL_RESP_OKAY       2'b00
`define LSL_RESP_SLVERR     2'b10

// Timing: clock period and least on-time before open-LED results count.
`define LSL_CLK_PERIOD_NS   100
`define LSL_MIN_ON_NS       1000
`define LSL_MIN_ON_CYC      ((`LSL_MIN_ON_NS + `LSL_CLK_PERIOD_NS - 1) / `LSL_CLK_PERIOD_NS)
`define LSL_ON_CNT_W        4

`endif

//--- common/lsl_pkg.sv
`include "lsl_regs.svh"

package lsl_pkg;

    // Serial link pins, kept together through the synchroniser.
    typedef struct packed {
        logic shift_clock;
        logic serial_in;
        logic latch_strobe;
        logic output_blank;
    } lsl_pins_t;

    // Analog indications from the comparators and temperature sensor.
    typedef struct packed {
        logic                       overtemp_hot;
        logic [`LSL_CHANNELS-1:0]   open_cmp;
    } lsl_sense_t;

    typedef logic [`LSL_CHANNELS-1:0] lsl_word_t;

endpackage : lsl_pkg

//--- hw/lsl_sync.sv
`timescale 1ns/10ps

module lsl_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Asynchronous input and its synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= INIT;
            q      <= INIT;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : lsl_sync

//--- hw/lsl_top.sv
`timescale 1ns/10ps
`include "lsl_regs.svh"

// Behaviour
// RL1 - Unblanked output follows its latch bit.
// RL2 - Blank high forces every output off.
// RL3 - Shift register and latch are 16 bits.
// RL4 - Shift clock rise shifts serial_in into LSB.
// RL5 - Strobe rise copies shift register to latch.
// RL6 - Same strobe rise loads status into shifter.
// RL7 - Controller strobes only once per update.
// RL8 - Controller holds blank high until data latched.
// RL9 - Controller zeroes unconnected outputs first.
// RL10 - Low pin on active output sets flag.
// RL11 - Controller waits minimum on-time for flags.
// RL12 - Overtemp warning follows hot indication.
// RL13 - Overtemp never switches outputs off.
// RL14 - Blank rise captures flags until fall.
// RL15 - Captured overtemp reports all flags one.
// RL16 - Status bit zero good, one faulty.
// RL17 - Controller reads status after blank rise.
// RL18 - All outputs switch together.
// RL19 - Bit n is channel n; MSB feeds serial_out.
// RL20 - Data registers have no reset.

module lsl_top
    import lsl_pkg::*;
#(
    parameter int CH = `LSL_CHANNELS
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Serial link pins
    input  wire logic                   shift_clock,
    input  wire logic                   serial_in,
    input  wire logic                   latch_strobe,
    input  wire logic                   output_blank,
    output logic                        serial_out,
    // Sink outputs and sensing
    output logic [CH-1:0]               sink_output_n,
    input  wire logic [CH-1:0]          open_cmp,
    input  wire logic                   overtemp_hot,
    output logic                        overtemp_warning,
    // AXI4-Lite write address and data
    input  wire logic [`LSL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`LSL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    localparam lsl_pins_t PINS_INIT = '{shift_clock: 1'b0, serial_in: 1'b0,
                                        latch_strobe: 1'b0, output_blank: 1'b1};

    lsl_pins_t              pins_raw;
    lsl_pins_t              pins_s;
    lsl_pins_t              pins_prev_q;
    lsl_sense_t             sense_raw;
    lsl_sense_t             sense_s;

    logic [CH-1:0]          shift_q;
    logic [CH-1:0]          onoff_q;
    logic [CH-1:0]          status_q;
    logic                   status_hot_q;
    logic [CH-1:0]          open_acc_q;
    logic [CH-1:0]          open_acc_d;
    logic [`LSL_ON_CNT_W-1:0] on_cnt_q;
    logic                   soft_blank_q;

    logic [`LSL_ADDR_W-1:0] awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   aw_held_q;
    logic                   w_held_q;

    assign pins_raw  = '{shift_clock: shift_clock, serial_in: serial_in,
                         latch_strobe: latch_strobe, output_blank: output_blank};
    assign sense_raw = '{overtemp_hot: overtemp_hot, open_cmp: open_cmp};

    lsl_sync #(
        .W    ($bits(lsl_pins_t)),
        .INIT (PINS_INIT)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (pins_raw),
        .q       (pins_s)
    );

    lsl_sync #(
        .W    ($bits(lsl_sense_t)),
        .INIT ('0)
    ) u_sense_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (sense_raw),
        .q       (sense_s)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pins_prev_q <= PINS_INIT;
        end else begin
            pins_prev_q <= pins_s;
        end
    end

    // Edge decode on the synchronised pins.
    wire shift_rise = pins_s.shift_clock & ~pins_prev_q.shift_clock;
    wire latch_rise = pins_s.latch_strobe & ~pins_prev_q.latch_strobe;
    wire blank_rise = pins_s.output_blank & ~pins_prev_q.output_blank;
    wire blank_fall = ~pins_s.output_blank & pins_prev_q.output_blank;
    wire blanked    = pins_s.output_blank | soft_blank_q;
    wire on_ok      = on_cnt_q >= `LSL_ON_CNT_W'(`LSL_MIN_ON_CYC);

    // RL15 all flags one
    wire [CH-1:0] status_capture = sense_s.overtemp_hot ? CH'(`LSL_ALL_ONES) : open_acc_d;

    // RL10 open flag accumulation
    assign open_acc_d = (blank_fall ? '0 : open_acc_q)
                        | (pins_s.output_blank ? '0 : (onoff_q & sense_s.open_cmp));

    // RL3 RL20 unreset data registers
    // RL4 shift on rise
    // RL5 latch copy
    // RL6 status into shifter
    always_ff @(posedge sys_clk) begin
        if (latch_rise) begin
            onoff_q <= shift_q;
            shift_q <= status_q;
        end else if (shift_rise) begin
            shift_q <= {shift_q[CH-2:0], pins_s.serial_in};
        end
    end

    // RL14 capture on blank rise
    // RL16 one marks fault
    always_ff @(posedge sys_clk) begin
        open_acc_q <= open_acc_d;
        if (blank_rise) begin
            status_q     <= status_capture;
            status_hot_q <= sense_s.overtemp_hot;
        end
    end

    // Counts time with the blank pin low, up to the minimum; the pin going high clears it, so on_ok is not kept with the captured flags.
    always_ff @(posedge sys_clk) begin
        if (rst || pins_s.output_blank) begin
            on_cnt_q <= '0;
        end else if (!on_ok) begin
            on_cnt_q <= on_cnt_q + `LSL_ON_CNT_W'(1);
        end
    end

    // RL1 RL2 gated outputs
    // RL13 overtemp does not gate
    // RL18 one register for all
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sink_output_n    <= '0;
            overtemp_warning <= 1'b0;
        end else begin
            sink_output_n    <= blanked ? '0 : onoff_q;
            // RL12 warning tracks hot
            overtemp_warning <= sense_s.overtemp_hot;
        end
    end

    // RL19 MSB drives chain
    always_ff @(posedge sys_clk) begin
        serial_out <= shift_q[CH-1];
    end

    // Register bus: address and data may come in either order.
    wire aw_take   = s_axi_awvalid & s_axi_awready;
    wire w_take    = s_axi_wvalid & s_axi_wready;
    wire ar_take   = s_axi_arvalid & s_axi_arready;
    wire wr_go     = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_ctrl   = wr_go & (awaddr_q == `LSL_OFS_CTRL) & wstrb_q[0];
    wire wr_mapped = (awaddr_q == `LSL_OFS_CTRL) | (awaddr_q == `LSL_OFS_ONOFF)
                     | (awaddr_q == `LSL_OFS_SHIFT) | (awaddr_q == `LSL_OFS_STATUS);

    wire [31:0] rd_status = {13'h0000, sense_s.overtemp_hot, on_ok, status_hot_q,
                             16'(status_q)};
    wire [31:0] rd_word   = (s_axi_araddr == `LSL_OFS_CTRL)   ? {31'h0, soft_blank_q} :
                            (s_axi_araddr == `LSL_OFS_ONOFF)  ? 32'(onoff_q) :
                            (s_axi_araddr == `LSL_OFS_SHIFT)  ? 32'(shift_q) :
                            (s_axi_araddr == `LSL_OFS_STATUS) ? rd_status : 32'h0000_0000;
    wire        rd_mapped = (s_axi_araddr == `LSL_OFS_CTRL) | (s_axi_araddr == `LSL_OFS_ONOFF)
                            | (s_axi_araddr == `LSL_OFS_SHIFT)
                            | (s_axi_araddr == `LSL_OFS_STATUS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LSL_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `LSL_RESP_OKAY : `LSL_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Soft blank only adds to the pin; it cannot unblank a blanked driver.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_blank_q <= `LSL_CTRL_RST;
        end else if (wr_ctrl) begin
            soft_blank_q <= wdata_q[`LSL_CTRL_SOFT_BLANK];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LSL_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `LSL_RESP_OKAY : `LSL_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule : lsl_top

//--- dv/lsl_top_sva.sv
`timescale 1ns/10ps
module lsl_top_sva #(
    parameter int CH = 16
) (
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          rst,
    // Link pins and sinks
    input wire logic          shift_clock,
    input wire logic          latch_strobe,
    input wire logic          output_blank,
    input wire logic          serial_out,
    input wire logic [CH-1:0] sink_output_n,
    input wire logic          overtemp_hot,
    input wire logic          overtemp_warning,
    // Bus handshakes
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Six samples cover the synchroniser and the output register.
    property p_blank; output_blank [*6] |-> sink_output_n == '0; endproperty
    a_blank: assert property (p_blank) else $error("lit while blanked");
    property p_hot_up; $rose(overtemp_hot) |-> ##[1:6] overtemp_warning; endproperty
    a_hot_up: assert property (p_hot_up) else $error("no warning");
    property p_hot_dn; $fell(overtemp_hot) |-> ##[1:6] !overtemp_warning; endproperty
    a_hot_dn: assert property (p_hot_dn) else $error("warning stuck");
    // A link pin is held for four samples, so three back still shows the edge.
    property p_serial_out; $changed(serial_out) |-> $past(shift_clock, 3) || $past(latch_strobe, 3);
    endproperty
    a_serial_out: assert property (p_serial_out) else $error("stray serial_out");
    property p_keep; !output_blank [*8] ##1 $rose(overtemp_warning) |-> $stable(sink_output_n);
    endproperty
    a_keep: assert property (p_keep) else $error("sinks cut by warning");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("no read answer");
    c_hot: cover property ($rose(overtemp_warning));
    c_lit: cover property (!output_blank && sink_output_n != '0);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : lsl_top_sva

bind lsl_top lsl_top_sva #(.CH(CH)) u_sva (.*);

//--- dv/lsl_ctrl_model.sv
`timescale 1ns/10ps
module lsl_ctrl_model
    import lsl_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Link pins
    output logic     shift_clock,
    output logic     serial_in,
    output logic     latch_strobe,
    output logic     output_blank,
    input wire logic serial_out
);
    initial begin
        {shift_clock, serial_in, latch_strobe} = 3'h0;
        output_blank = 1'b1;
    end
    // Four system cycles make half of the 800 ns link period.
    task automatic half();
        repeat (4) @(posedge sys_clk);
    endtask : half
    task automatic xfer(input lsl_word_t d, output lsl_word_t q);
        for (int i = 15; i >= 0; i--) begin
            serial_in <= d[i];
            half();
            q[i] = serial_out;
            shift_clock <= 1'b1;
            half();
            shift_clock <= 1'b0;
        end
        // The line never keeps the last bit, so a late sample cannot pass by luck.
        serial_in <= ~d[0];
        half();
    endtask : xfer
    task automatic strobe();
        latch_strobe <= 1'b1;
        half();
        latch_strobe <= 1'b0;
        half();
    endtask : strobe
    task automatic set_blank(input logic b);
        output_blank <= b;
        half();
        half();
    endtask : set_blank
endmodule : lsl_ctrl_model

//--- dv/tb.sv
`timescale 1ns/10ps
module tb
    import lsl_pkg::*;
;
    logic        sys_clk, rst, shift_clock, serial_in, latch_strobe, output_blank;
    logic        serial_out, overtemp_hot, overtemp_warning;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    lsl_word_t   sink_output_n, open_cmp, w1, w2, st, q;
    logic [33:0] exp_q[$];
    int          errors, tests_run, seed;
    lsl_top DUT (.*);
    lsl_ctrl_model u_ctl (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // Waits for arready, rvalid or bvalid; a hung bus ends the run.
    task automatic hs(input int k);
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (k == 0 ? s_axi_arready : k == 1 ? s_axi_rvalid : s_axi_bvalid) begin
                return;
            end
        end
        errors++;
        print_verdict();
    endtask : hs
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        for (int n = 0; n < 50 && (pa || pw); n++) begin
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            @(posedge sys_clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
        end
        // A write channel that is never taken ends the run as a hung bus.
        if (pa || pw) begin
            errors++;
            print_verdict();
        end
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(2);
        s_axi_bready <= 1'b1;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        check({32'h0, s_axi_bresp}, 34'h0);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        hs(0);
        s_axi_arvalid <= 1'b0;
        hs(1);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask : rd
    always @(posedge sys_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end
    // Two synchroniser flops and the output register, with margin.
    task automatic sink_is(input lsl_word_t e);
        repeat (6) @(posedge sys_clk);
        check({18'h0, sink_output_n}, {18'h0, e});
    endtask : sink_is
    initial begin
        {rst, overtemp_hot, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wstrb, s_axi_wdata, open_cmp} = {4'hF, 48'h0};
        errors = 0;
        tests_run = 0;
        seed = 32'h073D34A5;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        w1 = 16'($random(seed)) & 16'h7FFF;
        w2 = 16'($random(seed));
        sink_is('0);
        rd(4'h0, 34'h0);
        u_ctl.xfer(w1, q);
        u_ctl.strobe();
        rd(4'h4, {18'h0, w1});
        sink_is('0);
        u_ctl.set_blank(1'b0);
        sink_is(w1);
        wr(4'h0, 32'h1);
        sink_is('0);
        rd(4'h0, 34'h1);
        wr(4'h0, 32'h0);
        rd(4'h2, {2'b10, 32'h0});
        $display("on/off and bus tests done");
        for (int k = 0; k < 3; k++) begin
            open_cmp <= 16'($random(seed));
            u_ctl.set_blank(1'b0);
            repeat (12) @(posedge sys_clk);
            overtemp_hot <= (k == 1);
            sink_is(w1);
            check({33'h0, overtemp_warning}, {33'h0, k == 1});
            repeat (12) @(posedge sys_clk);
            st = (k == 1) ? 16'hFFFF : w1 & open_cmp;
            u_ctl.set_blank(1'b1);
            rd(4'hC, {15'h0, k == 1, 1'b0, k == 1, st});
            $display("status round %0d done", k);
        end
        u_ctl.xfer(w2, q);
        u_ctl.strobe();
        rd(4'h4, {18'h0, w2});
        u_ctl.xfer(w1, q);
        check({18'h0, q}, {18'h0, st});
        rd(4'h8, {18'h0, w1});
        u_ctl.set_blank(1'b0);
        sink_is(w2);
        $display("readout tests done");
        print_verdict();
    end
endmodule : tb
